// ### include/twsrp_consts.vh
`ifndef TWSRP_CONSTS_VH
`define TWSRP_CONSTS_VH
// Bus address (8-bit write form) answered when the strap is low.
`define TWSRP_ADDR_STRAP_LO 8'h90
// Bus address (8-bit write form) answered when the strap is high.
`define TWSRP_ADDR_STRAP_HI 8'hBA
// Bits in a serial byte.
`define TWSRP_BYTE_BITS 4'h8
// Width of register address and register data.
`define TWSRP_REG_WIDTH 16
// Depth of the pin synchronisers.
`define TWSRP_SYNC_STAGES 2
`endif

// ### verilog/twsrp_sync.v
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for one asynchronous input, frozen while the enable is low.
module twsrp_sync #(
    parameter RESET_VAL = 1'b1
) (
    input wire clk,
    input wire rst_b,
    input wire clkEn,
    input wire asyncIn,
    output wire syncOut
);
    // First stage; only the second stage reads it.
    reg meta_r;
    // Second stage, safe to use.
    reg stable_r;

    // Both stages shift together on every enabled edge.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= RESET_VAL;
            stable_r <= RESET_VAL;
        end else if (clkEn) begin
            meta_r <= asyncIn;
            stable_r <= meta_r;
        end
    end

    assign syncOut = stable_r;
endmodule // twsrp_sync
`default_nettype wire

// ### verilog/twsrp_port.v
`timescale 1ns/1ps
`default_nettype none
`include "twsrp_consts.vh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Slave-only serial access to internal registers.
// - Start, address byte, register address, data, stop.
// - Both lines high means the bus idles.
// - Strap low answers 0x90, high 0xBA.
// - Programmed address overrides strap default.
// - Start is data falling while clock high.
// - Repeated start begins fresh address phase.
// - Bytes MSB first, data stable clock high.
// - Ninth bit acknowledge; no-acknowledge ends reads.
// - Stop is data rising while clock high.
// - Address, data two bytes each, MSB first.
module twsrp_port #(
    parameter REG_WIDTH = `TWSRP_REG_WIDTH
) (
    input wire clk,
    input wire rst_b,
    input wire clkEn,
    input wire serialClockIn,
    input wire serialDataLineIn,
    output wire serialDataLineOut,
    output wire serialDataLineOe_b,
    input wire addressSelectStrap,
    input wire [6:0] progAddr,
    input wire progAddrValid,
    output reg [REG_WIDTH-1:0] regAddr,
    output reg [REG_WIDTH-1:0] regWrData,
    output reg regWrStrobe,
    output reg regRdStrobe,
    input wire [REG_WIDTH-1:0] regRdData,
    output wire busIdle,
    output reg busBusy
);
    ////////////////////////////////////////////////////////////////////////////
    // One-hot states of the byte sequencer.
    localparam [6:0] ST_IDLE = 7'h01;
    localparam [6:0] ST_DEVADDR = 7'h02;
    localparam [6:0] ST_ADDRHI = 7'h04;
    localparam [6:0] ST_ADDRLO = 7'h08;
    localparam [6:0] ST_WRDATA = 7'h10;
    localparam [6:0] ST_RDDATA = 7'h20;
    localparam [6:0] ST_IGNORE = 7'h40;

    // Synchronised line levels and their previous samples.
    wire sclSync;
    wire sdaSync;
    reg sclPrev_r;
    reg sdaPrev_r;

    // Synchronise serial clock and data before any logic sees them.
    twsrp_sync #(.RESET_VAL(1'b1)) uSyncScl (
        .clk(clk),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .asyncIn(serialClockIn),
        .syncOut(sclSync)
    );
    twsrp_sync #(.RESET_VAL(1'b1)) uSyncSda (
        .clk(clk),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .asyncIn(serialDataLineIn),
        .syncOut(sdaSync)
    );

    // Delayed copies for edge detection.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sclPrev_r <= 1'b1;
            sdaPrev_r <= 1'b1;
        end else if (clkEn) begin
            sclPrev_r <= sclSync;
            sdaPrev_r <= sdaSync;
        end
    end

    // Edges and bus conditions; only the master creates them, we only watch.
    wire sclRise = sclSync & ~sclPrev_r;
    wire sclFall = ~sclSync & sclPrev_r;
    wire startCond = sclSync & sclPrev_r & sdaPrev_r & ~sdaSync;
    wire stopCond = sclSync & sclPrev_r & ~sdaPrev_r & sdaSync;
    assign busIdle = sclSync & sdaSync;

    ////////////////////////////////////////////////////////////////////////////
    // Strap is caught after reset release, never by the asynchronous reset.
    reg strapSeen_r;
    reg strapLatched_r;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            strapSeen_r <= 1'b0;
            strapLatched_r <= 1'b0;
        end else if (clkEn && !strapSeen_r) begin
            strapSeen_r <= 1'b1;
            strapLatched_r <= addressSelectStrap;
        end
    end

    // Programmed address overrides the strap choice.
    wire [7:0] strapAddr = strapLatched_r ? `TWSRP_ADDR_STRAP_HI : `TWSRP_ADDR_STRAP_LO;
    wire [6:0] myAddr = progAddrValid ? progAddr : strapAddr[7:1];

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer registers.
    reg [6:0] state_r;
    reg [3:0] bitCnt_r; // Bit in byte; 8 is the acknowledge slot.
    reg [7:0] shift_r; // Received or transmitted byte.
    reg readDir_r; // Current transfer reads.
    reg ackDrive_r; // Pull the data line low.
    reg txBit_r; // Bit driven during a read.
    reg txActive_r; // Slave drives data bits.
    reg byteHi_r; // Write: next data byte is the high byte; read: byte being sent is the high byte.
    reg [7:0] wrHi_r; // Held high byte of write data.
    reg masterNack_r; // Master declined the last read byte.

    // Drive low only: open-drain, enable active low while driving.
    wire driveLow = ackDrive_r | (txActive_r & ~txBit_r);
    assign serialDataLineOut = 1'b0;
    assign serialDataLineOe_b = ~driveLow;

    // Byte receive/transmit sequencer.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
            bitCnt_r <= 4'h0;
            shift_r <= 8'h00;
            readDir_r <= 1'b0;
            ackDrive_r <= 1'b0;
            txBit_r <= 1'b1;
            txActive_r <= 1'b0;
            byteHi_r <= 1'b1;
            wrHi_r <= 8'h00;
            masterNack_r <= 1'b0;
            regAddr <= {REG_WIDTH{1'b0}};
            regWrData <= {REG_WIDTH{1'b0}};
            regWrStrobe <= 1'b0;
            regRdStrobe <= 1'b0;
            busBusy <= 1'b0;
        end else if (clkEn) begin
            regWrStrobe <= 1'b0;
            regRdStrobe <= 1'b0;
            // Step past a written word only after its strobe cycle, so the
            // register side sees the address that belongs to the data.
            if (regWrStrobe) begin
                regAddr <= regAddr + 16'h0002;
            end
            if (startCond) begin
                // Start or repeated start opens a fresh address phase.
                state_r <= ST_DEVADDR;
                // The clock fall that closes the start wraps this to zero.
                bitCnt_r <= 4'hF;
                ackDrive_r <= 1'b0;
                txActive_r <= 1'b0;
                busBusy <= 1'b1;
            end else if (stopCond) begin
                // Stop releases the bus and the line.
                state_r <= ST_IDLE;
                ackDrive_r <= 1'b0;
                txActive_r <= 1'b0;
                busBusy <= 1'b0;
            end else if (sclRise && bitCnt_r < `TWSRP_BYTE_BITS) begin
                // Sample MSB first on the rising edge, data stable while high.
                // While reading, the shifter holds our own outgoing bits instead.
                if (state_r != ST_RDDATA) begin
                    shift_r <= {shift_r[6:0], sdaSync};
                end
            end else if (sclRise) begin
                // Acknowledge slot: in a read, a high line is a no-acknowledge.
                masterNack_r <= sdaSync;
                // Ask for the next word half a serial period before it is loaded.
                if ((state_r == ST_DEVADDR && readDir_r && ackDrive_r) ||
                        (state_r == ST_RDDATA && !byteHi_r && !sdaSync)) begin
                    regRdStrobe <= 1'b1;
                end
            end else if (sclFall) begin
                case (state_r)
                    ST_IDLE, ST_IGNORE: begin
                        // Not addressed: stay off the line.
                        bitCnt_r <= 4'h0;
                    end
                    default: begin
                        if (bitCnt_r == 4'h7) begin
                            // Eighth bit done: decide acknowledge.
                            bitCnt_r <= `TWSRP_BYTE_BITS;
                            txActive_r <= 1'b0;
                            case (state_r)
                                ST_DEVADDR: begin
                                    if (shift_r[7:1] == myAddr) begin
                                        ackDrive_r <= 1'b1;
                                        readDir_r <= shift_r[0];
                                    end else begin
                                        state_r <= ST_IGNORE;
                                    end
                                end
                                ST_RDDATA: begin
                                    // The master acknowledges reads, not us.
                                    ackDrive_r <= 1'b0;
                                end
                                default: begin
                                    // Every received byte is acknowledged.
                                    ackDrive_r <= 1'b1;
                                end
                            endcase
                        end else if (bitCnt_r == `TWSRP_BYTE_BITS) begin
                            // Acknowledge slot done: move to the next byte.
                            bitCnt_r <= 4'h0;
                            ackDrive_r <= 1'b0;
                            case (state_r)
                                ST_DEVADDR: begin
                                    if (readDir_r) begin
                                        state_r <= ST_RDDATA;
                                        byteHi_r <= 1'b1;
                                        shift_r <= {regRdData[REG_WIDTH-2:REG_WIDTH-8], 1'b0};
                                        txBit_r <= regRdData[REG_WIDTH-1];
                                        txActive_r <= 1'b1;
                                    end else begin
                                        state_r <= ST_ADDRHI;
                                    end
                                end
                                ST_ADDRHI: begin
                                    // High address byte arrives first.
                                    regAddr <= {shift_r, regAddr[7:0]};
                                    state_r <= ST_ADDRLO;
                                end
                                ST_ADDRLO: begin
                                    regAddr <= {regAddr[REG_WIDTH-1:8], shift_r};
                                    state_r <= ST_WRDATA;
                                    byteHi_r <= 1'b1;
                                end
                                ST_WRDATA: begin
                                    // Two bytes, MSB first, form one write.
                                    if (byteHi_r) begin
                                        wrHi_r <= shift_r;
                                        byteHi_r <= 1'b0;
                                    end else begin
                                        regWrData <= {wrHi_r, shift_r};
                                        regWrStrobe <= 1'b1;
                                        byteHi_r <= 1'b1;
                                    end
                                end
                                ST_RDDATA: begin
                                    if (masterNack_r) begin
                                        // No-acknowledge ends the read.
                                        state_r <= ST_IGNORE;
                                    end else begin
                                        txActive_r <= 1'b1;
                                        if (byteHi_r) begin
                                            shift_r <= {regRdData[6:0], 1'b0};
                                            txBit_r <= regRdData[7];
                                            byteHi_r <= 1'b0;
                                            regAddr <= regAddr + 16'h0002;
                                        end else begin
                                            shift_r <= {regRdData[14:8], 1'b0};
                                            txBit_r <= regRdData[15];
                                            byteHi_r <= 1'b1;
                                        end
                                    end
                                end
                                default: begin
                                    state_r <= ST_IGNORE;
                                end
                            endcase
                        end else begin
                            bitCnt_r <= bitCnt_r + 4'h1;
                            if (state_r == ST_RDDATA) begin
                                // Next bit out while the clock is low.
                                txBit_r <= shift_r[7];
                                shift_r <= {shift_r[6:0], 1'b0};
                            end
                        end
                    end
                endcase
            end
        end
    end
endmodule // twsrp_port
`default_nettype wire

// ### tb/twsrp_port_properties.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Pin-level protocol checks on the serial slave port.
module twsrp_checker (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic serialClockIn,
    input wire logic serialDataLineIn,
    input wire logic serialDataLineOut,
    input wire logic serialDataLineOe_b,
    input wire logic regWrStrobe,
    input wire logic regRdStrobe,
    input wire logic busIdle,
    input wire logic busBusy
);
    // Every check runs on the core clock and rests during reset.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_pull_low_only: assert property (serialDataLineOut == 1'b0)
        else $error("slave data output not low");
    a_idle_high: assert property ((serialClockIn && serialDataLineIn)[*5] |-> busIdle)
        else $error("idle missed with both lines high");
    a_idle_low: assert property ((!serialClockIn)[*5] |-> !busIdle)
        else $error("idle shown with clock low");
    a_start_busy: assert property ($fell(serialDataLineIn) && serialClockIn |-> ##[1:6] busBusy)
        else $error("start not followed by busy");
    a_stop_free: assert property ($rose(serialDataLineIn) && serialClockIn |-> ##[1:8] !busBusy)
        else $error("stop not followed by free bus");
    a_drive_clk_low: assert property ($changed(serialDataLineOe_b) |-> !serialClockIn)
        else $error("slave changed data while clock high");
    a_quiet_free: assert property (!busBusy |-> serialDataLineOe_b)
        else $error("slave drives a free bus");
    a_wr_pulse: assert property (regWrStrobe |=> !regWrStrobe && busBusy)
        else $error("write strobe too long or outside frame");
    a_rd_pulse: assert property (regRdStrobe |=> !regRdStrobe)
        else $error("read strobe too long");
endmodule // twsrp_checker
bind twsrp_port twsrp_checker chk_u (.clk(clk), .rst_b(rst_b), .serialClockIn(serialClockIn),
    .serialDataLineIn(serialDataLineIn), .serialDataLineOut(serialDataLineOut),
    .serialDataLineOe_b(serialDataLineOe_b), .regWrStrobe(regWrStrobe),
    .regRdStrobe(regRdStrobe), .busIdle(busIdle), .busBusy(busBusy));
`default_nettype wire

// ### tb/twsrp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Bus master model; its clock stands high between frames, data is open drain.
module twsrp_host_model (
    output logic sclOut,
    output logic sdaDrv,
    input wire logic sdaIn
);
    // Both lines released gives the idle bus.
    initial begin
        sclOut = 1'b1;
        sdaDrv = 1'b1;
    end
    // One bit per 80 ns clock period; data moves only while the clock is low.
    task bitX(input logic b, output logic r);
        sdaDrv = b;
        #20 sclOut = 1'b1;
        #20 r = sdaIn;
        #20 sclOut = 1'b0;
        #20;
    endtask
    // Start or repeated start: data falls while the clock is high.
    task startCond;
        sdaDrv = 1'b1;
        #20 sclOut = 1'b1;
        #20 sdaDrv = 1'b0;
        #20 sclOut = 1'b0;
        #20;
    endtask
    // Stop: data rises while the clock is high.
    task stopCond;
        sdaDrv = 1'b0;
        #20 sclOut = 1'b1;
        #20 sdaDrv = 1'b1;
        #40;
    endtask
    // Sends a byte MSB first, then releases the line for the acknowledge.
    task sendByte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitX(d[i], r);
        bitX(1'b1, ack);
    endtask
    // Reads a byte, then acknowledges or refuses it.
    task getByte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bitX(1'b1, d[i]);
        bitX(nack, r);
    endtask
endmodule // twsrp_host_model
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench: writes, reads, address choice and refusals.
module testbench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic strap = 1'b0;
    logic [6:0] progAddr = 7'h00;
    logic progAddrValid = 1'b0;
    logic [15:0] regRdData = 16'h0000;
    logic [7:0] lfsr = 8'h26; // Fixed seed keeps the run repeatable.
    logic [15:0] wrAddrQ[$];
    logic [15:0] wrDataQ[$];
    logic [15:0] a;
    logic [31:0] w;
    logic k;
    int errors = 0;
    int checked = 0;
    wire sclLine, sdaDrv, sdaOut, sdaOe_b, idle, busy, wrStb, rdStb;
    wire [15:0] regAddr, regWrData;
    wire sdaLine = sdaDrv & (sdaOe_b | sdaOut); // Pulled-up shared data wire.
    always #2 clk = ~clk;
    twsrp_port dut_u (.clk(clk), .rst_b(rst_b), .clkEn(1'b1), .serialClockIn(sclLine),
        .serialDataLineIn(sdaLine), .serialDataLineOut(sdaOut), .serialDataLineOe_b(sdaOe_b),
        .addressSelectStrap(strap), .progAddr(progAddr), .progAddrValid(progAddrValid),
        .regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(wrStb), .regRdStrobe(rdStb),
        .regRdData(regRdData), .busIdle(idle), .busBusy(busy));
    twsrp_host_model host_u (.sclOut(sclLine), .sdaDrv(sdaDrv), .sdaIn(sdaLine));
    function automatic logic [7:0] lfsrNext(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // Register contents seen by the port: a fixed scramble of the address.
    function automatic logic [15:0] rdModel(input logic [15:0] ad);
        return ad ^ 16'hA5C3;
    endfunction
    // Answers each read request and records each write.
    always @(posedge clk) begin
        if (rdStb === 1'b1) regRdData <= #1 rdModel(regAddr);
        if (wrStb === 1'b1) begin
            wrAddrQ.push_back(regAddr);
            wrDataQ.push_back(regWrData);
        end
    end
    task rnd32(output logic [31:0] v);
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsrNext(lfsr);
            v[i*8+:8] = lfsr;
        end
    endtask
    task rstDev(input logic s);
        @(posedge clk) #1 rst_b = 1'b0;
        strap = s;
        repeat (20) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (8) @(posedge clk);
    endtask
    // Address byte then four message bytes; a refused address must write nothing.
    task probe(input logic [7:0] dev, input logic ex);
        wrAddrQ.delete();
        rnd32(w);
        host_u.startCond();
        host_u.sendByte(dev, k);
        `CHECK("address ack", ex, k)
        for (int i = 3; i >= 0; i--) host_u.sendByte(w[i*8+:8], k);
        host_u.stopCond();
        #100;
        `CHECK("write count", ex ? 0 : 1, wrAddrQ.size())
        `CHECK("idle", 1'b1, idle)
        `CHECK("busy", 1'b0, busy)
    endtask
    task hdr(input logic [15:0] ad);
        host_u.startCond();
        host_u.sendByte(8'h90, k);
        `CHECK("write address ack", 1'b0, k)
        host_u.sendByte(ad[15:8], k);
        `CHECK("address high ack", 1'b0, k)
        host_u.sendByte(ad[7:0], k);
        `CHECK("address low ack", 1'b0, k)
    endtask
    task conclude;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #300000 errors++;
        conclude();
    end
    // Main sequence: strap low, bursts of writes and reads, strap high, programmed address.
    initial begin
        rstDev(1'b0);
        probe(8'h90, 1'b0);
        probe(8'hBA, 1'b1);
        for (int n = 0; n < 3; n++) begin
            rnd32(w);
            a = {w[31:17], 1'b0};
            rnd32(w);
            wrAddrQ.delete();
            wrDataQ.delete();
            hdr(a);
            `CHECK("busy in frame", 1'b1, busy)
            for (int i = 3; i >= 0; i--) begin
                host_u.sendByte(w[i*8+:8], k);
                `CHECK("data ack", 1'b0, k)
            end
            host_u.stopCond();
            #100;
            `CHECK("word count", 2, wrAddrQ.size())
            `CHECK("first address", a, wrAddrQ[0])
            `CHECK("next address", a + 16'h0002, wrAddrQ[1])
            `CHECK("word data", w, {wrDataQ[0], wrDataQ[1]})
            hdr(a);
            host_u.startCond();
            host_u.sendByte(8'h91, k);
            `CHECK("read address ack", 1'b0, k)
            for (int i = 3; i >= 0; i--) host_u.getByte(i == 0, w[i*8+:8]);
            host_u.stopCond();
            `CHECK("read words", {rdModel(a), rdModel(a + 16'h0002)}, w)
        end
        rstDev(1'b1);
        probe(8'hBA, 1'b0);
        probe(8'h90, 1'b1);
        @(posedge clk) #1 progAddrValid = 1'b1;
        progAddr = {2'b11, lfsr[4:0]};
        probe({progAddr, 1'b0}, 1'b0);
        probe(8'hBA, 1'b1);
        conclude();
    end
endmodule // testbench
`default_nettype wire
